// file: dv/debug_trigger_csrs_sva.sv
// Port assertions for the debug and trigger register block.
`timescale 1ns/1ps
`include "debug_trigger_map.svh"
module debug_trigger_csrs_sva
    import debug_trigger_pkg::*;
(
    input wire logic clock, // Core clock.
    input wire logic rst, // Synchronous reset.
    input wire csr_req_t req, // CSR access.
    input wire logic machine_mode, // Machine privilege.
    input wire logic debug_enter, // Entry pulse.
    input wire logic [2:0] debug_cause, // Entry cause.
    input wire logic [31:0] current_pc, // PC at entry.
    input wire logic debug_exit, // Exit pulse.
    input wire csr_rsp_t rsp, // Access result.
    input wire logic in_debug, // Debug mode.
    input wire logic resume_valid, // Resume pulse.
    input wire logic [31:0] resume_pc // Resume address.
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic rd_ok;
    assign rd_ok = req.valid && req.op == CSR_READ && !rsp.illegal;
    sequence enter_s; debug_enter && !in_debug; endsequence
    // The exit cycle carries no access, so a late resume PC write cannot blur the check.
    sequence exit_s; debug_exit && in_debug && !req.valid; endsequence
    dbg_guard_a: assert property (req.valid && req.addr[11:2] == 10'h1EC && req.addr[1:0] != 2'h3
        && !in_debug |-> rsp.illegal) else $error("debug register open outside debug");
    trig_reach_a: assert property (req.valid && req.addr == `CSR_TRIGGER_SELECT &&
        (in_debug || machine_mode) |-> rsp.hit && !rsp.illegal) else $error("select refused");
    entry_resume_a: assert property (enter_s ##1 exit_s |=> resume_valid && !in_debug
        && resume_pc == $past(current_pc, 2)) else $error("resume address not entry PC");
    exit_pulse_a: assert property (debug_exit && in_debug |=> resume_valid ##1 !resume_valid)
        else $error("resume pulse wrong");
    quiet_resume_a: assert property (!(debug_exit && in_debug) |=> !resume_valid)
        else $error("resume pulse without exit");
    illegal_zero_a: assert property (rsp.illegal |-> rsp.rdata == 32'h0)
        else $error("refused access returned data");
    select_legal_a: assert property (rd_ok && req.addr == `CSR_TRIGGER_SELECT
        |-> rsp.rdata < `TRIGGER_BANK_COUNT) else $error("select holds missing bank");
    type_code_a: assert property (rd_ok && req.addr == `CSR_TRIGGER_DATA_FIRST
        |-> rsp.rdata[31:28] == `TYPE_ADDR_MATCH && rsp.rdata[26:21] == `MASKMAX_VALUE)
        else $error("type or range field wrong");
    cause_seen_a: assert property (enter_s ##1 rd_ok && req.addr == `CSR_DEBUG_CTRL
        |-> rsp.rdata[8:6] == $past(debug_cause)) else $error("entry cause not reported");
endmodule : debug_trigger_csrs_sva
bind debug_trigger_csrs debug_trigger_csrs_sva checker_i (.clock(clock), .rst(rst), .req(req),
    .machine_mode(machine_mode), .debug_enter(debug_enter), .debug_cause(debug_cause),
    .current_pc(current_pc), .debug_exit(debug_exit), .rsp(rsp), .in_debug(in_debug),
    .resume_valid(resume_valid), .resume_pc(resume_pc));

// file: dv/hart_pipe_model.sv
// Hart pipeline model that issues register accesses and debug entry and exit.
`timescale 1ns/1ps
module hart_pipe_model
    import debug_trigger_pkg::*;
(
    input wire logic clock, // Core clock.
    input wire csr_rsp_t rsp, // Access result.
    output csr_req_t req, // Access request.
    output logic machine_mode, // Machine privilege.
    output logic debug_enter, // Entry pulse.
    output logic [2:0] debug_cause, // Entry cause.
    output logic [31:0] current_pc, // PC at entry.
    output logic debug_exit // Exit pulse.
);
    initial begin
        req = '0;
        machine_mode = 1'b1;
        {debug_enter, debug_exit, debug_cause, current_pc} = '0;
    end
    // An idle cycle follows each access and shows inverted fields, so stale data never passes.
    task automatic access(input csr_op_t op, input logic [11:0] a, input logic [31:0] d,
            input logic [31:0] m, output csr_rsp_t seen);
        @(posedge clock);
        debug_enter <= 1'b0;
        debug_exit <= 1'b0;
        req <= '{1'b1, op, a, d, m};
        #1;
        seen = rsp;
        @(posedge clock);
        req <= '{1'b0, CSR_NONE, ~a, ~d, ~m};
    endtask : access
    task automatic step(input logic en, input logic ex, input logic [31:0] pc, input logic [2:0] c);
        @(posedge clock);
        debug_enter <= en;
        debug_exit <= ex;
        current_pc <= pc;
        debug_cause <= c;
    endtask : step
    task automatic set_mode(input logic m);
        @(posedge clock);
        machine_mode <= m;
    endtask : set_mode
endmodule : hart_pipe_model

// file: dv/test_debug_trigger_csrs.sv
// Self-checking testbench for the debug and trigger register block.
`timescale 1ns/1ps
`include "debug_trigger_map.svh"
module test_debug_trigger_csrs;
    import debug_trigger_pkg::*;
    logic clock;
    logic rst;
    csr_req_t req;
    csr_rsp_t rsp;
    csr_rsp_t seen;
    logic machine_mode, debug_enter, debug_exit, in_debug, resume_valid;
    logic [2:0] debug_cause;
    logic [31:0] current_pc, resume_pc;
    int num_errors = 0;
    int checks_done = 0;
    debug_trigger_csrs DUT (.clock(clock), .rst(rst), .req(req), .machine_mode(machine_mode),
        .debug_enter(debug_enter), .debug_cause(debug_cause), .current_pc(current_pc),
        .debug_exit(debug_exit), .rsp(rsp), .in_debug(in_debug), .resume_valid(resume_valid),
        .resume_pc(resume_pc));
    hart_pipe_model pipe (.clock(clock), .rsp(rsp), .req(req), .machine_mode(machine_mode),
        .debug_enter(debug_enter), .debug_cause(debug_cause), .current_pc(current_pc),
        .debug_exit(debug_exit));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ill);
        pipe.access(CSR_READ, a, 32'h0, 32'h0, seen);
        check({31'h0, seen.illegal}, {31'h0, ill});
        check(seen.rdata, exp);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        pipe.access(CSR_WRITE, a, d, 32'h0, seen);
    endtask : wr
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #8000;
        num_errors++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(`CSR_TRIGGER_SELECT, 32'h0, 1'b0);
        rd(`CSR_TRIGGER_DATA_FIRST, 32'h2080_0000, 1'b0);
        rd(`CSR_DEBUG_CTRL, 32'h0, 1'b1);
        wr(`CSR_TRIGGER_SELECT, 32'h5);
        rd(`CSR_TRIGGER_SELECT, 32'h0, 1'b0);
        wr(`CSR_TRIGGER_SELECT, 32'h1);
        rd(`CSR_TRIGGER_DATA_FIRST, 32'h2080_0000, 1'b0);
        wr(`CSR_TRIGGER_DATA_SECOND, 32'hA5A5_0001);
        wr(`CSR_TRIGGER_DATA_THIRD, 32'h1234_5678);
        rd(`CSR_TRIGGER_DATA_SECOND, 32'hA5A5_0001, 1'b0);
        rd(`CSR_TRIGGER_DATA_THIRD, 32'h0, 1'b0);
        wr(`CSR_TRIGGER_SELECT, 32'h2);
        rd(`CSR_TRIGGER_SELECT, 32'h1, 1'b0);
        wr(`CSR_TRIGGER_SELECT, 32'h0);
        rd(`CSR_TRIGGER_DATA_SECOND, 32'h0, 1'b0);
        pipe.set_mode(1'b0);
        rd(`CSR_TRIGGER_SELECT, 32'h0, 1'b1);
        pipe.set_mode(1'b1);
        pipe.step(1'b1, 1'b0, 32'h8000_0100, 3'h3);
        pipe.step(1'b0, 1'b1, 32'h8000_0100, 3'h3);
        pipe.step(1'b0, 1'b0, 32'h8000_0100, 3'h3);
        #1;
        check({31'h0, resume_valid}, 32'h1);
        check(resume_pc, 32'h8000_0100);
        pipe.step(1'b1, 1'b0, 32'h8000_0200, 3'h2);
        pipe.access(CSR_READ, `CSR_DEBUG_CTRL, 32'h0, 32'h0, seen);
        check({29'h0, seen.rdata[8:6]}, 32'h2);
        rd(`CSR_DEBUG_RESUME_PC, 32'h8000_0200, 1'b0);
        wr(`CSR_DEBUG_SCRATCH, 32'h0F0F_0F0F);
        pipe.access(CSR_SET_CLEAR, `CSR_DEBUG_SCRATCH, 32'h1000_0000, 32'h0000_000F, seen);
        rd(`CSR_DEBUG_SCRATCH, 32'h1F0F_0F00, 1'b0);
        wr(`CSR_TRIGGER_SELECT, 32'h1);
        // An even unsupported action code must fall back to zero, with no stray action bit kept.
        wr(`CSR_TRIGGER_DATA_FIRST, 32'h0002_0000);
        rd(`CSR_TRIGGER_DATA_FIRST, 32'h2080_0000, 1'b0);
        wr(`CSR_TRIGGER_DATA_FIRST, 32'h0800_0044);
        rd(`CSR_TRIGGER_DATA_FIRST, 32'h2880_0044, 1'b0);
        wr(`CSR_DEBUG_RESUME_PC, 32'h8000_0300);
        pipe.step(1'b0, 1'b1, 32'h8000_0200, 3'h2);
        pipe.step(1'b0, 1'b0, 32'h8000_0200, 3'h2);
        #1;
        check(resume_pc, 32'h8000_0300);
        check({31'h0, in_debug}, 32'h0);
        rd(`CSR_TRIGGER_DATA_SECOND, 32'h0, 1'b1);
        rd(`CSR_DEBUG_SCRATCH, 32'h0, 1'b1);
        end_of_test();
    end
endmodule : test_debug_trigger_csrs

// file: hdl/debug_trigger_csrs.sv
// Per-hart debug and trigger control-status registers with access checks.
//
// Summary of operation
// - Trigger select and data: debug or machine mode.
// - Debug control, resume PC, scratch: debug only.
// - First and second data addresses reach the selected trigger bank.
// - Select keeps only indices of implemented banks.
// - Second data is full-width read/write; first data keeps only legal fields.
// - Top nibble of first data is type.
// - Type 0 none, 2 address match, others reserved.
// - Machine access to debug-only bank is illegal.
// - Debug entry copies current PC to resume PC.
// - Debug exit resumes at held resume PC.
// - Debug control shows capabilities and status.
// - Exactly two breakpoint banks are implemented.
// - Implemented banks report type code 2.
`timescale 1ns/1ps
`include "debug_trigger_map.svh"
module debug_trigger_csrs
    import debug_trigger_pkg::*;
(
    input wire logic clock, // Core clock, 125 MHz.
    input wire logic rst, // Synchronous reset, active high.
    input wire csr_req_t req, // CSR access from the pipeline.
    input wire logic machine_mode, // Hart runs at machine privilege.
    input wire logic debug_enter, // One-cycle pulse: enter debug mode.
    input wire logic [2:0] debug_cause, // Reason for entering debug mode.
    input wire logic [31:0] current_pc, // PC of the instruction at entry.
    input wire logic debug_exit, // One-cycle pulse: leave debug mode.
    output csr_rsp_t rsp, // Access result, combinational.
    output logic in_debug, // Hart is in debug mode.
    output logic resume_valid, // One-cycle pulse with resume address.
    output logic [31:0] resume_pc // Address to resume at after debug.
);
    hart_state_t state_q;
    logic [31:0] select_q;
    logic [31:0] dcsr_q;
    logic [31:0] dpc_q;
    logic [31:0] dscratch_q;
    logic [31:0] bank_first [2];
    logic [31:0] bank_second [2];
    logic [1:0] bank_dmode;
    logic [1:0] wr_first;
    logic [1:0] wr_second;
    logic [31:0] new_value;
    logic [31:0] cur_value;
    logic bank_exists;
    logic bank_locked;
    logic is_trigger;
    logic is_debug_reg;
    logic do_write;

    function automatic logic [31:0] apply_op(input csr_op_t op, input logic [31:0] old,
                                             input logic [31:0] wd, input logic [31:0] cm);
        logic [31:0] r;
        r = old;
        unique case (op)
            CSR_WRITE: r = wd;
            CSR_SET_CLEAR: r = (old | wd) & ~cm;
            CSR_READ, CSR_NONE: r = old;
        endcase
        return r;
    endfunction : apply_op

    assign in_debug = (state_q == HART_DEBUG);
    assign bank_exists = (select_q < `TRIGGER_BANK_COUNT);
    assign bank_locked = bank_exists && bank_dmode[select_q[0]];
    assign is_trigger = (req.addr == `CSR_TRIGGER_SELECT) || (req.addr == `CSR_TRIGGER_DATA_FIRST)
        || (req.addr == `CSR_TRIGGER_DATA_SECOND) || (req.addr == `CSR_TRIGGER_DATA_THIRD);
    assign is_debug_reg = (req.addr == `CSR_DEBUG_CTRL) || (req.addr == `CSR_DEBUG_RESUME_PC)
        || (req.addr == `CSR_DEBUG_SCRATCH);

    // Response decode: read value and legality of the access.
    always_comb begin
        rsp.hit = req.valid && (is_trigger || is_debug_reg);
        rsp.illegal = 1'b0;
        rsp.rdata = 32'h0000_0000;
        if (req.valid && is_trigger) begin
            if (!(in_debug || machine_mode)) begin
                rsp.illegal = 1'b1;
            end else if (!in_debug && bank_locked && req.addr != `CSR_TRIGGER_SELECT) begin
                rsp.illegal = 1'b1;
            end
        end
        if (req.valid && is_debug_reg && !in_debug) begin
            rsp.illegal = 1'b1;
        end
        if (rsp.hit && !rsp.illegal) begin
            unique case (req.addr)
                `CSR_TRIGGER_SELECT: rsp.rdata = select_q;
                `CSR_TRIGGER_DATA_FIRST: begin
                    // Missing bank reads all zero, so its type reads as none.
                    rsp.rdata = bank_exists ? bank_first[select_q[0]] : 32'h0000_0000;
                end
                `CSR_TRIGGER_DATA_SECOND: begin
                    rsp.rdata = bank_exists ? bank_second[select_q[0]] : 32'h0000_0000;
                end
                `CSR_DEBUG_CTRL: rsp.rdata = dcsr_q;
                `CSR_DEBUG_RESUME_PC: rsp.rdata = dpc_q;
                `CSR_DEBUG_SCRATCH: rsp.rdata = dscratch_q;
                default: rsp.rdata = 32'h0000_0000;
            endcase
        end
    end

    assign cur_value = rsp.rdata;
    assign new_value = apply_op(req.op, cur_value, req.wdata, req.clear_mask);
    assign do_write = rsp.hit && !rsp.illegal && (req.op == CSR_WRITE || req.op == CSR_SET_CLEAR);

    // Writes to a missing bank, or to the reserved third word, are dropped.
    always_comb begin
        wr_first = 2'b00;
        wr_second = 2'b00;
        if (do_write && bank_exists) begin
            if (req.addr == `CSR_TRIGGER_DATA_FIRST) begin
                wr_first[select_q[0]] = 1'b1;
            end
            if (req.addr == `CSR_TRIGGER_DATA_SECOND) begin
                wr_second[select_q[0]] = 1'b1;
            end
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_bank
        trigger_bank u_bank (
            .clock(clock),
            .rst(rst),
            .wr_first(wr_first[i]),
            .wr_second(wr_second[i]),
            .wdata(new_value),
            .first_q(bank_first[i]),
            .second_q(bank_second[i]),
            .dmode(bank_dmode[i])
        );
    end

    // Out-of-range indices are not retained; the old index stays. Machine mode may not
    // write a locked bank, so a locked bank only unlocks from debug mode.
    always_ff @(posedge clock) begin
        if (rst) begin
            select_q <= 32'h0000_0000;
        end else if (do_write && req.addr == `CSR_TRIGGER_SELECT
                     && new_value < `TRIGGER_BANK_COUNT) begin
            select_q <= new_value;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= HART_RUNNING;
        end else if (debug_enter && !in_debug) begin
            state_q <= HART_DEBUG;
        end else if (debug_exit && in_debug) begin
            state_q <= HART_RUNNING;
        end
    end

    // Entry has priority over a same-cycle software write of the resume PC.
    always_ff @(posedge clock) begin
        if (rst) begin
            dpc_q <= 32'h0000_0000;
        end else if (debug_enter && !in_debug) begin
            dpc_q <= current_pc;
        end else if (do_write && req.addr == `CSR_DEBUG_RESUME_PC) begin
            dpc_q <= new_value;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            dscratch_q <= 32'h0000_0000;
        end else if (do_write && req.addr == `CSR_DEBUG_SCRATCH) begin
            dscratch_q <= new_value;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            dcsr_q <= `DCSR_RESET;
        end else if (debug_enter && !in_debug) begin
            dcsr_q[`DCSR_CAUSE_LO +: 3] <= debug_cause;
        end else if (do_write && req.addr == `CSR_DEBUG_CTRL) begin
            dcsr_q <= (dcsr_q & ~`DCSR_WRITABLE_MASK) | (new_value & `DCSR_WRITABLE_MASK);
        end
    end

    // Resume address is the live register, so a write made during debug takes effect.
    always_ff @(posedge clock) begin
        if (rst) begin
            resume_valid <= 1'b0;
            resume_pc <= 32'h0000_0000;
        end else begin
            resume_valid <= debug_exit && in_debug;
            resume_pc <= dpc_q;
        end
    end
endmodule : debug_trigger_csrs

// file: hdl/debug_trigger_map.svh
// Register numbers, field positions and reset values of the debug and trigger registers.
`ifndef DEBUG_TRIGGER_MAP_SVH
`define DEBUG_TRIGGER_MAP_SVH
`define CSR_TRIGGER_SELECT 12'h7A0
`define CSR_TRIGGER_DATA_FIRST 12'h7A1
`define CSR_TRIGGER_DATA_SECOND 12'h7A2
`define CSR_TRIGGER_DATA_THIRD 12'h7A3
`define CSR_DEBUG_CTRL 12'h7B0
`define CSR_DEBUG_RESUME_PC 12'h7B1
`define CSR_DEBUG_SCRATCH 12'h7B2
`define TRIGGER_BANK_COUNT 32'h0000_0002
`define TRIGGER_DATA_FIRST_TYPE_HI 31
`define TRIGGER_DATA_FIRST_TYPE_LO 28
`define TRIGGER_DATA_FIRST_DMODE_BIT 27
`define TRIGGER_DATA_FIRST_MASKMAX_HI 26
`define TRIGGER_DATA_FIRST_MASKMAX_LO 21
`define TYPE_NONE 4'h0
`define TYPE_ADDR_MATCH 4'h2
`define MASKMAX_VALUE 6'h04
`define TRIGGER_DATA_FIRST_WRITABLE_MASK 32'h0800_1FFF
`define TRIGGER_DATA_FIRST_ACTION_MASK 32'h0003_F000
`define DCSR_RESET 32'h4000_0003
`define DCSR_WRITABLE_MASK 32'h0000_B004
`define DCSR_CAUSE_LO 6
`endif

// file: hdl/debug_trigger_pkg.sv
// Types shared by the debug and trigger register block.
package debug_trigger_pkg;
    typedef enum logic [1:0] {CSR_NONE, CSR_READ, CSR_WRITE, CSR_SET_CLEAR} csr_op_t;
    typedef struct packed {
        logic valid;
        csr_op_t op;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] clear_mask;
    } csr_req_t;
    typedef struct packed {
        logic hit;
        logic illegal;
        logic [31:0] rdata;
    } csr_rsp_t;
    typedef enum {HART_RUNNING, HART_DEBUG} hart_state_t;
endpackage : debug_trigger_pkg

// file: hdl/trigger_bank.sv
// One breakpoint trigger bank: match control and match address words.
`timescale 1ns/1ps
`include "debug_trigger_map.svh"
module trigger_bank
    import debug_trigger_pkg::*;
(
    input wire logic clock, // Core clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic wr_first, // Write strobe for the control word.
    input wire logic wr_second, // Write strobe for the address word.
    input wire logic [31:0] wdata, // Value to store.
    output logic [31:0] first_q, // Control word as read back.
    output logic [31:0] second_q, // Address word.
    output logic dmode // Bank reserved for debug mode.
);
    logic [31:0] ctrl_q;

    function automatic logic [31:0] legal_ctrl(input logic [31:0] v);
        logic [31:0] r;
        r = v & `TRIGGER_DATA_FIRST_WRITABLE_MASK;
        // Only actions 0 and 1 exist; other codes lose bits 17:13 but keep bit 12, so even codes fall back to action 0 and odd codes to action 1.
        if (v[17:13] == 5'h00) begin
            r = r | (v & `TRIGGER_DATA_FIRST_ACTION_MASK);
        end
        return r;
    endfunction : legal_ctrl

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q <= 32'h0000_0000;
        end else if (wr_first) begin
            ctrl_q <= legal_ctrl(wdata);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            second_q <= 32'h0000_0000;
        end else if (wr_second) begin
            second_q <= wdata;
        end
    end

    always_comb begin
        first_q = ctrl_q;
        first_q[`TRIGGER_DATA_FIRST_TYPE_HI:`TRIGGER_DATA_FIRST_TYPE_LO] = `TYPE_ADDR_MATCH;
        first_q[`TRIGGER_DATA_FIRST_MASKMAX_HI:`TRIGGER_DATA_FIRST_MASKMAX_LO] = `MASKMAX_VALUE;
    end

    assign dmode = ctrl_q[`TRIGGER_DATA_FIRST_DMODE_BIT];
endmodule : trigger_bank
